/* common/sac_pkg.sv */
// Constants for the successive-approximation conversion controller
package sac_pkg;
    localparam int unsigned RES_BITS       = 12;
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned WAKE_TIME_NS   = 10_000;
    localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
    localparam int unsigned WAKE_CYCLES    =
        (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_SLOTS     = 16;
    localparam int unsigned BIT_SLOT_FIRST = 2;
    localparam logic [11:0] RESULT_RESET   = 12'h000;

    typedef enum logic [1:0] {
        SAC_WAKE   = 2'b00,
        SAC_IDLE   = 2'b01,
        SAC_SAMPLE = 2'b10,
        SAC_RESOLV = 2'b11
    } sac_state_t;
endpackage

/* verilog/sac_ctrl.sv */
// Conversion sequencer for a 12-bit successive-approximation converter
`timescale 1ns/1ps
module sac_ctrl
    import sac_pkg::*;
(
    input  wire logic                SYS_CLK_IN,
    input  wire logic                RST_IN,
    input  wire logic                CONV_TICK_IN,
    input  wire logic                SLEEP_IN,
    input  wire logic                SW_START_IN,
    input  wire logic                FRAME_START_IN,
    input  wire logic                SINGLE_SHOT_IN,
    input  wire logic                CMP_IN,
    input  wire logic                RESULT_READ_IN,
    output logic [RES_BITS-1:0]      DAC_CODE_OUT,
    output logic                     SAMPLE_OUT,
    output logic                     READY_OUT,
    output logic                     BUSY_OUT,
    output logic                     STATUS_DONE_OUT,
    output logic                     CONV_DONE_OUT,
    output logic [RES_BITS-1:0]      RESULT_OUT
);
    // Frame-start and comparator come from outside the clock domain
    logic [2:0] fs_sync_q;
    logic [2:0] cmp_sync_q;
    logic       fs_level_q;
    logic       cmp_level_q;
    logic       fs_pend_q;

    sac_state_t                state_q;
    logic [12:0]               wake_cnt_q;
    logic [3:0]                slot_q;
    logic [3:0]                bit_q;
    logic [RES_BITS-1:0]       sar_q;
    logic [RES_BITS-1:0]       result_q;
    logic                      done_q;

    wire fs_agree   = fs_sync_q[1] == fs_sync_q[2];
    wire cmp_agree  = cmp_sync_q[1] == cmp_sync_q[2];
    wire fs_rise    = fs_agree && fs_sync_q[2] && !fs_level_q;
    wire wake_done  = wake_cnt_q == 13'(WAKE_CYCLES);
    wire idle       = state_q == SAC_IDLE;
    wire fs_req     = fs_rise || fs_pend_q;
    wire trig       = SINGLE_SHOT_IN ? (SW_START_IN || fs_req)
                                     : 1'b1;
    wire start      = idle && trig && CONV_TICK_IN;
    // A frame edge that falls between ticks while idle waits here for the next tick
    wire fs_pend_d  = idle && SINGLE_SHOT_IN && !start && fs_req;
    wire bit_slot   = state_q == SAC_RESOLV && CONV_TICK_IN;
    wire last_bit   = bit_q == 4'h0;
    wire complete   = bit_slot && last_bit;
    wire [RES_BITS-1:0] bit_mask = RES_BITS'(1) << bit_q;
    wire [RES_BITS-1:0] kept     = cmp_level_q ? sar_q : (sar_q & ~bit_mask);
    wire [RES_BITS-1:0] trial_next =
        last_bit ? kept : (kept | (bit_mask >> 1));

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            fs_sync_q   <= 3'h0;
            cmp_sync_q  <= 3'h0;
            fs_level_q  <= 1'b0;
            cmp_level_q <= 1'b0;
            fs_pend_q   <= 1'b0;
        end else begin
            fs_sync_q  <= {fs_sync_q[1:0], FRAME_START_IN};
            cmp_sync_q <= {cmp_sync_q[1:0], CMP_IN};
            fs_pend_q  <= fs_pend_d;
            if (fs_agree) begin
                fs_level_q <= fs_sync_q[2];
            end
            if (cmp_agree) begin
                cmp_level_q <= cmp_sync_q[2];
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wake_cnt_q <= 13'h0;
        end else if (SLEEP_IN) begin
            wake_cnt_q <= 13'h0;
        end else if (!wake_done) begin
            wake_cnt_q <= wake_cnt_q + 13'h1;
        end
    end

    // Sample for two ticks, then fix one bit on each tick
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_q <= SAC_WAKE;
            slot_q  <= 4'h0;
            bit_q   <= 4'h0;
            sar_q   <= RESULT_RESET;
        end else if (SLEEP_IN) begin
            state_q <= SAC_WAKE;
        end else begin
            unique case (state_q)
                SAC_WAKE: begin
                    if (wake_done) begin
                        state_q <= SAC_IDLE;
                    end
                end
                SAC_IDLE: begin
                    if (start) begin
                        state_q <= SAC_SAMPLE;
                        slot_q  <= 4'h0;
                    end
                end
                SAC_SAMPLE: begin
                    if (CONV_TICK_IN) begin
                        slot_q <= slot_q + 4'h1;
                        if (slot_q == 4'(BIT_SLOT_FIRST - 1)) begin
                            state_q <= SAC_RESOLV;
                            bit_q   <= 4'(RES_BITS - 1);
                            sar_q   <= RESULT_RESET | (RES_BITS'(1)
                                       << (RES_BITS - 1));
                        end
                    end
                end
                SAC_RESOLV: begin
                    if (CONV_TICK_IN) begin
                        slot_q <= slot_q + 4'h1;
                        sar_q  <= trial_next;
                        if (!last_bit) begin
                            bit_q <= bit_q - 4'h1;
                        end else begin
                            state_q <= SAC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            result_q <= RESULT_RESET;
            done_q   <= 1'b0;
        end else begin
            if (complete) begin
                result_q <= trial_next;
            end
            // Completion wins over a read landing in the same cycle
            if (complete) begin
                done_q <= 1'b1;
            end else if (RESULT_READ_IN) begin
                done_q <= 1'b0;
            end
        end
    end

    assign DAC_CODE_OUT    = sar_q;
    assign SAMPLE_OUT      = state_q == SAC_SAMPLE;
    assign READY_OUT       = idle;
    assign BUSY_OUT        = state_q == SAC_SAMPLE || state_q == SAC_RESOLV;
    assign STATUS_DONE_OUT = done_q;
    assign CONV_DONE_OUT   = done_q;
    assign RESULT_OUT      = result_q;

    property p_wake_block;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        !wake_done |-> !BUSY_OUT && !start;
    endproperty
    AST_WAKE_BLOCK: assert property (p_wake_block)
        else $error("Conversion started during wake wait");

    property p_done_hold;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        CONV_DONE_OUT && !RESULT_READ_IN |=> CONV_DONE_OUT;
    endproperty
    AST_DONE_HOLD: assert property (p_done_hold)
        else $error("Done dropped without a read");

    property p_done_set;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        complete |=> CONV_DONE_OUT && STATUS_DONE_OUT;
    endproperty
    AST_DONE_SET: assert property (p_done_set)
        else $error("Done not set at completion");

    property p_read_clr;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        RESULT_READ_IN && !complete |=> !STATUS_DONE_OUT;
    endproperty
    AST_READ_CLR: assert property (p_read_clr)
        else $error("Read did not clear status");

    property p_res_stable;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        !$past(complete) |-> $stable(RESULT_OUT);
    endproperty
    AST_RES_STABLE: assert property (p_res_stable)
        else $error("Result changed without completion");

    property p_no_restart;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        BUSY_OUT && SW_START_IN |=> !SAMPLE_OUT || $past(SAMPLE_OUT);
    endproperty
    AST_NO_RESTART: assert property (p_no_restart)
        else $error("Start accepted while busy");

    // Entry into the search phase, and in that same cycle the trial code with only the MSB set
    sequence s_enter_resolve;
        $rose(state_q == SAC_RESOLV);
    endsequence
    sequence s_search_top;
        bit_q == 4'(RES_BITS - 1) && DAC_CODE_OUT == 12'h800;
    endsequence
    property p_msb_first;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        s_enter_resolve |-> s_search_top;
    endproperty
    AST_MSB_FIRST: assert property (p_msb_first)
        else $error("Search did not start at MSB");

    property p_cont_run;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        idle && !SINGLE_SHOT_IN && CONV_TICK_IN && !SLEEP_IN |=> SAMPLE_OUT;
    endproperty
    AST_CONT_RUN: assert property (p_cont_run)
        else $error("Continuous mode did not restart");

    property p_one_per_trig;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        idle && SINGLE_SHOT_IN && !SW_START_IN && !fs_req |=> !SAMPLE_OUT;
    endproperty
    AST_ONE_PER_TRIG: assert property (p_one_per_trig)
        else $error("Single-shot converted without trigger");
endmodule

/* tb/sac_reader.sv */
// Comparator and result reader that sit beyond the converter
`timescale 1ns/1ps
module sac_reader
    import sac_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                done_in,
    input  wire logic                slow_in,
    input  wire logic [RES_BITS-1:0] vin_in,
    input  wire logic [RES_BITS-1:0] dac_in,
    output logic                     cmp_out,
    output logic                     read_out
);
    int wait_q = 0;
    assign cmp_out = (vin_in >= dac_in);
    // Reads the result two or twenty-one cycles after completion
    always @(posedge clk_in) begin
        read_out <= 1'b0;
        if (done_in && !read_out) begin
            wait_q <= wait_q + 1;
            if (wait_q >= (slow_in ? 20 : 1)) begin
                read_out <= 1'b1;
                wait_q <= 0;
            end
        end
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module testbench
    import sac_pkg::*;
;
    logic        clk = 0, rst = 1, tick = 0, sleep = 0, sw = 0;
    logic        frame = 0, single = 1, slow = 0, bad = 0;
    logic        cmp, rd, ready, busy, stat, done, done_p = 0, rd_p = 0;
    logic        smp, smp_p = 0;
    logic [11:0] vin = 12'h000, lv, dac, res;
    logic [11:0] q[$];
    int          checked = 0, miscompares = 0, ndone = 0, cyc = 0, w = 0;
    int          lo = WAKE_CYCLES - 1, hi = WAKE_CYCLES + 2;
    sac_ctrl DUT (.SYS_CLK_IN(clk), .RST_IN(rst), .CONV_TICK_IN(tick),
        .SLEEP_IN(sleep), .SW_START_IN(sw), .FRAME_START_IN(frame),
        .SINGLE_SHOT_IN(single), .CMP_IN(cmp), .RESULT_READ_IN(rd),
        .DAC_CODE_OUT(dac), .SAMPLE_OUT(smp), .READY_OUT(ready),
        .BUSY_OUT(busy), .STATUS_DONE_OUT(stat), .CONV_DONE_OUT(done),
        .RESULT_OUT(res));
    sac_reader far_end (.clk_in(clk), .done_in(done), .slow_in(slow),
        .vin_in(vin), .dac_in(dac), .cmp_out(cmp), .read_out(rd));
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_done(input int t);
        for (int i = 0; i < 1000 && ndone < t; i++) @(negedge clk);
        if (ndone < t) begin
            miscompares++;
            give_verdict();
        end
    endtask
    task automatic conv(input bit src, input logic s, input logic [11:0] v);
        int t;
        t = ndone + 1;
        q.push_back(v);
        @(posedge clk);
        vin <= v;
        slow <= s;
        if (src) frame <= 1'b1;
        else sw <= 1'b1;
        // Held past the start so repeats land while busy
        repeat (60) @(posedge clk);
        sw <= 1'b0;
        frame <= 1'b0;
        wait_done(t);
    endtask
    initial forever #25 clk = ~clk;
    // One conversion tick every 8 cycles, 2.5 MHz
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tick <= (cyc % 8 == 7);
        if (cyc == 12000) begin
            miscompares++;
            give_verdict();
        end
    end
    always @(negedge clk) begin
        if (done && !done_p) begin
            ndone++;
            chk(12'(q.size() > 0), 12'h001);
            if (q.size() > 0) chk(res, q.pop_front());
            chk(12'(stat), 12'h001);
        end
        if (rd) chk(12'(done), 12'h001);
        if (rd_p) chk(12'(stat), 12'h000);
        if (smp_p && !smp && !sleep) chk(dac, 12'h800);
        done_p = done;
        rd_p = rd;
        smp_p = smp;
    end
    initial begin
        void'($urandom(32'h2ad3));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        sw <= 1'b1;
        repeat (WAKE_CYCLES - 10) begin
            @(negedge clk);
            w++;
            if (busy || ready) bad = 1'b1;
        end
        @(posedge clk);
        sw <= 1'b0;
        while (!ready && w < 400) begin
            @(negedge clk);
            w++;
        end
        chk(12'(bad), 12'h000);
        chk(12'(w >= lo && w <= hi), 12'h001);
        for (int i = 0; i < 8; i++) begin
            lv = i == 0 ? 12'hfff : i == 1 ? 12'h000 : 12'($urandom);
            conv(i[0], i > 3, lv);
        end
        lv = 12'($urandom);
        repeat (3) q.push_back(lv);
        @(posedge clk);
        vin <= lv;
        single <= 1'b0;
        wait_done(ndone + 3);
        @(posedge clk);
        sleep <= 1'b1;
        repeat (10) @(posedge clk);
        sleep <= 1'b0;
        single <= 1'b1;
        @(negedge clk);
        chk(12'({ready, busy}), 12'h000);
        w = 1;
        while (!ready && w < 400) begin
            @(negedge clk);
            w++;
        end
        chk(12'(w >= lo && w <= hi), 12'h001);
        repeat (250) @(negedge clk);
        chk(12'(q.size()), 12'h000);
        give_verdict();
    end
endmodule
